// ---- src/sltun_top.sv ----
// servo loop tuning: feedforward, P/PI mode switch, force reference filter chain, APB slave
// How it works
// - feedforward adds position reference step times gain percent, 0..100, reset zero.
// - feedforward passes a first-order lag; zero constant means no filtering.
// - speed loop switches automatically between P-only and PI control.
// - selector picks force, speed, acceleration, position error, or none; immediate.
// - force mode: P-only while force magnitude exceeds level, 0..800, reset 200.
// - speed mode: P-only while speed reference exceeds level, 0..10000.
// - acceleration mode: P-only while acceleration exceeds level, 0..30000.
// - position error mode: P-only while position error exceeds level, 0..10000.
// - position error condition acts only while the drive runs position control.
// - force path is lag then second-step filter in series, each independent.
// - force lag constant 0..65535 in 0.01 ms, reset 100, immediate.
// - second-step filter cutoff 100..5000 Hz, reset 5000.
// - cutoff of 5000 bypasses the second-step filter entirely.
// - second-step Q 50..100 in 0.01 steps, reset 50, immediate.
// - notch select: digit 0 enables first notch, digit 2 the second.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sltun_top #(
  parameter int DW = sltun_pkg::DATA_W
) (
  input wire logic pclk,                          // APB and loop clock, 125 MHz
  input wire logic presetn,                       // async reset, low
  input wire logic psel,                          // APB select
  input wire logic penable,                       // APB access phase
  input wire logic pwrite,                        // APB write
  input wire logic [7:0] paddr,                   // APB byte address
  input wire logic [31:0] pwdata,                 // APB write data
  output logic [31:0] prdata,                     // APB read data
  output logic pready,                            // APB ready
  output logic pslverr,                           // APB error
  input wire logic sample_valid,                  // one speed loop update
  input wire sltun_pkg::sltun_sample_type sample, // loop quantities
  input wire logic pos_ctrl_mode,                 // drive is in position control
  output logic ff_valid,                          // feedforward updated
  output logic signed [DW-1:0] ff_out,            // filtered feedforward
  output logic force_valid,                       // force reference updated
  output logic signed [DW-1:0] force_out,         // filtered force reference
  output logic p_only,                            // speed loop in P-only control
  output logic notch1_en,                         // first notch stage enable
  output logic notch2_en                          // second notch stage enable
);
  if (DW != sltun_pkg::DATA_W) begin : g_bad_width
    $error("sltun_top: DW must match carrier width");
  end

  // settings
  logic [15:0] ff_gain_r;
  logic [15:0] ff_tc_r;
  logic [3:0] sw_sel_r;
  logic [15:0] force_lvl_r;
  logic [15:0] speed_lvl_r;
  logic [15:0] accel_lvl_r;
  logic [15:0] poserr_lvl_r;
  logic [15:0] lag_tc_r;
  logic [15:0] ss_freq_r;
  logic [15:0] ss_q_r;
  logic p_only_r;
  logic p_only_nxt;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // ---------------- APB decode ----------------
  logic setup_ph;
  logic access_ph;
  logic wr_commit;
  logic [15:0] wv;
  logic upper_zero;
  logic hit_ff_gain, hit_ff_tc, hit_sw_sel, hit_force, hit_speed, hit_accel;
  logic hit_poserr, hit_lag, hit_ss_freq, hit_ss_q, hit_notch, hit_status;
  logic mapped;
  logic wr_in_range;
  logic err_nxt;
  logic [31:0] rd_mux;
  logic [15:0] notch_word;
  logic [31:0] status_word;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_commit = access_ph && pready_r && pwrite && !pslverr_r;
  assign wv = pwdata[15:0];
  assign upper_zero = (pwdata[31:16] == 16'h0000);
  assign hit_ff_gain = (paddr == sltun_pkg::OFS_FF_GAIN);
  assign hit_ff_tc = (paddr == sltun_pkg::OFS_FF_TC);
  assign hit_sw_sel = (paddr == sltun_pkg::OFS_SW_SEL);
  assign hit_force = (paddr == sltun_pkg::OFS_FORCE_LVL);
  assign hit_speed = (paddr == sltun_pkg::OFS_SPEED_LVL);
  assign hit_accel = (paddr == sltun_pkg::OFS_ACCEL_LVL);
  assign hit_poserr = (paddr == sltun_pkg::OFS_POSERR_LVL);
  assign hit_lag = (paddr == sltun_pkg::OFS_LAG_TC);
  assign hit_ss_freq = (paddr == sltun_pkg::OFS_SS_FREQ);
  assign hit_ss_q = (paddr == sltun_pkg::OFS_SS_Q);
  assign hit_notch = (paddr == sltun_pkg::OFS_NOTCH_SEL);
  assign hit_status = (paddr == sltun_pkg::OFS_STATUS);
  assign mapped = hit_ff_gain || hit_ff_tc || hit_sw_sel || hit_force || hit_speed ||
                  hit_accel || hit_poserr || hit_lag || hit_ss_freq || hit_ss_q ||
                  hit_notch || hit_status;

  // out-of-range values are refused with pslverr and leave the setting untouched
  assign wr_in_range = upper_zero && (
      (hit_ff_gain && wv <= sltun_pkg::MAX_FF_GAIN) ||
      (hit_ff_tc && wv <= sltun_pkg::MAX_FF_TC) ||
      (hit_sw_sel && wv <= 16'(sltun_pkg::COND_NONE)) ||
      (hit_force && wv <= sltun_pkg::MAX_FORCE_LVL) ||
      (hit_speed && wv <= sltun_pkg::MAX_SPEED_LVL) ||
      (hit_accel && wv <= sltun_pkg::MAX_ACCEL_LVL) ||
      (hit_poserr && wv <= sltun_pkg::MAX_POSERR_LVL) ||
      hit_lag ||
      (hit_ss_freq && wv >= sltun_pkg::MIN_SS_FREQ && wv <= sltun_pkg::MAX_SS_FREQ) ||
      (hit_ss_q && wv >= sltun_pkg::MIN_SS_Q && wv <= sltun_pkg::MAX_SS_Q) ||
      (hit_notch && (wv & 16'hFEFE) == 16'h0000));
  assign err_nxt = pwrite ? !wr_in_range : !mapped;

  assign notch_word = {7'h00, notch2_en, 7'h00, notch1_en};
  assign status_word = {29'h0000_0000, ss_freq_r == sltun_pkg::SS_BYPASS_FREQ,
                        pos_ctrl_mode, p_only_r};
  assign rd_mux = ({32{hit_ff_gain}} & {16'h0000, ff_gain_r}) |
                  ({32{hit_ff_tc}} & {16'h0000, ff_tc_r}) |
                  ({32{hit_sw_sel}} & {28'h000_0000, sw_sel_r}) |
                  ({32{hit_force}} & {16'h0000, force_lvl_r}) |
                  ({32{hit_speed}} & {16'h0000, speed_lvl_r}) |
                  ({32{hit_accel}} & {16'h0000, accel_lvl_r}) |
                  ({32{hit_poserr}} & {16'h0000, poserr_lvl_r}) |
                  ({32{hit_lag}} & {16'h0000, lag_tc_r}) |
                  ({32{hit_ss_freq}} & {16'h0000, ss_freq_r}) |
                  ({32{hit_ss_q}} & {16'h0000, ss_q_r}) |
                  ({32{hit_notch}} & {16'h0000, notch_word}) |
                  ({32{hit_status}} & status_word);

  // answer prepared in setup so the access phase completes in its first cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup_ph;
      pslverr_r <= setup_ph && err_nxt;
      prdata_r <= (setup_ph && !pwrite && mapped) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff_gain_r <= sltun_pkg::RST_FF_GAIN;
      ff_tc_r <= sltun_pkg::RST_FF_TC;
      sw_sel_r <= sltun_pkg::RST_SW_SEL;
      force_lvl_r <= sltun_pkg::RST_FORCE_LVL;
      speed_lvl_r <= sltun_pkg::RST_SPEED_LVL;
      accel_lvl_r <= sltun_pkg::RST_ACCEL_LVL;
      poserr_lvl_r <= sltun_pkg::RST_POSERR_LVL;
      lag_tc_r <= sltun_pkg::RST_LAG_TC;
      ss_freq_r <= sltun_pkg::RST_SS_FREQ;
      ss_q_r <= sltun_pkg::RST_SS_Q;
      notch1_en <= 1'b0;
      notch2_en <= 1'b0;
    end else if (wr_commit) begin
      if (hit_ff_gain) ff_gain_r <= wv;
      if (hit_ff_tc) ff_tc_r <= wv;
      if (hit_sw_sel) sw_sel_r <= wv[3:0];
      if (hit_force) force_lvl_r <= wv;
      if (hit_speed) speed_lvl_r <= wv;
      if (hit_accel) accel_lvl_r <= wv;
      if (hit_poserr) poserr_lvl_r <= wv;
      if (hit_lag) lag_tc_r <= wv;
      if (hit_ss_freq) ss_freq_r <= wv;
      if (hit_ss_q) ss_q_r <= wv;
      if (hit_notch) begin
        notch1_en <= wv[0];
        notch2_en <= wv[8];
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ---------------- mode switch ----------------
  logic over_force, over_speed, over_accel, over_poserr;

  assign over_force = sltun_pkg::mag(sample.force_ref) > DW'(force_lvl_r);
  assign over_speed = sltun_pkg::mag(sample.speed_ref) > DW'(speed_lvl_r);
  assign over_accel = sltun_pkg::mag(sample.accel_ref) > DW'(accel_lvl_r);
  // position error is ignored outside position control
  assign over_poserr = pos_ctrl_mode &&
                       (sltun_pkg::mag(sample.pos_err) > DW'(poserr_lvl_r));

  always_comb begin
    case (sw_sel_r)
      sltun_pkg::COND_FORCE: p_only_nxt = over_force;
      sltun_pkg::COND_SPEED: p_only_nxt = over_speed;
      sltun_pkg::COND_ACCEL: p_only_nxt = over_accel;
      sltun_pkg::COND_POSERR: p_only_nxt = over_poserr;
      default: p_only_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_only_r <= 1'b0;
    end else if (sample_valid) begin
      p_only_r <= p_only_nxt;
    end
  end
  assign p_only = p_only_r;

  // ---------------- feedforward ----------------
  logic signed [DW+8-1:0] ff_prod;
  logic signed [DW-1:0] ff_scaled;

  // kept signed end to end so a negative step truncates toward zero
  assign ff_prod = (DW+8)'($signed(sample.pos_ff)) * $signed((DW+8)'({1'b0, ff_gain_r[7:0]}));
  assign ff_scaled = DW'(ff_prod / $signed((DW+8)'({1'b0, sltun_pkg::PERCENT_FULL})));

  sltun_lag #(.DW(DW), .STEP(sltun_pkg::LAG_STEP)) u_ff_lag (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(sample_valid),
    .x(ff_scaled),
    .tc(ff_tc_r),
    .out_valid(ff_valid),
    .y(ff_out)
  );

  // ---------------- force reference chain ----------------
  // notch stages sit downstream, steered by notch1_en and notch2_en
  logic lag_valid;
  logic signed [DW-1:0] lag_force;

  sltun_lag #(.DW(DW), .STEP(sltun_pkg::LAG_STEP)) u_force_lag (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(sample_valid),
    .x(sample.force_ref),
    .tc(lag_tc_r),
    .out_valid(lag_valid),
    .y(lag_force)
  );

  sltun_so2 #(.DW(DW)) u_second_step (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(lag_valid),
    .x(lag_force),
    .freq(ss_freq_r),
    .q(ss_q_r),
    .out_valid(force_valid),
    .y(force_out)
  );

  // ---------------- checks ----------------
  a_ff_gain_range: assert property (@(posedge pclk) disable iff (!presetn)
    ff_gain_r <= sltun_pkg::MAX_FF_GAIN) else $error("feedforward gain out of range");

  a_ff_tc_range: assert property (@(posedge pclk) disable iff (!presetn)
    ff_tc_r <= sltun_pkg::MAX_FF_TC) else $error("feedforward tc out of range");

  a_switch_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    sample_valid && sw_sel_r == sltun_pkg::COND_NONE |=> !p_only) else
    $error("mode switch active while disabled");

  a_force_switch: assert property (@(posedge pclk) disable iff (!presetn)
    sample_valid && sw_sel_r == sltun_pkg::COND_FORCE |=>
    p_only == (sltun_pkg::mag($past(sample.force_ref)) > DW'($past(force_lvl_r)))) else
    $error("force condition mismatch");

  a_speed_switch: assert property (@(posedge pclk) disable iff (!presetn)
    sample_valid && sw_sel_r == sltun_pkg::COND_SPEED |=>
    p_only == (sltun_pkg::mag($past(sample.speed_ref)) > DW'($past(speed_lvl_r)))) else
    $error("speed condition mismatch");

  a_accel_switch: assert property (@(posedge pclk) disable iff (!presetn)
    sample_valid && sw_sel_r == sltun_pkg::COND_ACCEL |=>
    p_only == (sltun_pkg::mag($past(sample.accel_ref)) > DW'($past(accel_lvl_r)))) else
    $error("acceleration condition mismatch");

  a_poserr_posonly: assert property (@(posedge pclk) disable iff (!presetn)
    sample_valid && sw_sel_r == sltun_pkg::COND_POSERR && !pos_ctrl_mode |=> !p_only) else
    $error("position error switched outside position control");

  a_poserr_switch: assert property (@(posedge pclk) disable iff (!presetn)
    sample_valid && sw_sel_r == sltun_pkg::COND_POSERR && pos_ctrl_mode |=>
    p_only == (sltun_pkg::mag($past(sample.pos_err)) > DW'($past(poserr_lvl_r)))) else
    $error("position error condition mismatch");

  a_hold_between: assert property (@(posedge pclk) disable iff (!presetn)
    !sample_valid |=> $stable(p_only)) else $error("mode changed without loop update");

  a_chain_latency: assert property (@(posedge pclk) disable iff (!presetn)
    sample_valid |-> ##2 force_valid) else $error("force chain latency wrong");

  a_ss_freq_range: assert property (@(posedge pclk) disable iff (!presetn)
    ss_freq_r >= sltun_pkg::MIN_SS_FREQ && ss_freq_r <= sltun_pkg::MAX_SS_FREQ &&
    ss_q_r >= sltun_pkg::MIN_SS_Q && ss_q_r <= sltun_pkg::MAX_SS_Q) else
    $error("second step setting out of range");

  c_force_ponly: cover property (@(posedge pclk) disable iff (!presetn)
    sw_sel_r == sltun_pkg::COND_FORCE && $rose(p_only));
  c_poserr_ponly: cover property (@(posedge pclk) disable iff (!presetn)
    sw_sel_r == sltun_pkg::COND_POSERR && $rose(p_only));
  c_wr_refused: cover property (@(posedge pclk) disable iff (!presetn)
    access_ph && pwrite && pslverr_r);
  c_ss_active: cover property (@(posedge pclk) disable iff (!presetn)
    force_valid && ss_freq_r != sltun_pkg::SS_BYPASS_FREQ);

endmodule // sltun_top
`default_nettype wire

// ---- src/sltun_pkg.sv ----
// package: constants, offsets, reset values and carrier type for the servo tuning block
package sltun_pkg;

  localparam int DATA_W = 24;
  localparam int FRAC_W = 8;

  typedef struct packed {
    logic signed [DATA_W-1:0] force_ref; // 1% of rated force
    logic signed [DATA_W-1:0] speed_ref; // 1 mm/s
    logic signed [DATA_W-1:0] accel_ref; // 1 mm/s^2
    logic signed [DATA_W-1:0] pos_err;   // reference units
    logic signed [DATA_W-1:0] pos_ff;    // position reference step per loop update
  } sltun_sample_type;

  // register byte offsets
  localparam logic [7:0] OFS_FF_GAIN = 8'h00;
  localparam logic [7:0] OFS_FF_TC = 8'h04;
  localparam logic [7:0] OFS_SW_SEL = 8'h08;
  localparam logic [7:0] OFS_FORCE_LVL = 8'h0C;
  localparam logic [7:0] OFS_SPEED_LVL = 8'h10;
  localparam logic [7:0] OFS_ACCEL_LVL = 8'h14;
  localparam logic [7:0] OFS_POSERR_LVL = 8'h18;
  localparam logic [7:0] OFS_LAG_TC = 8'h1C;
  localparam logic [7:0] OFS_SS_FREQ = 8'h20;
  localparam logic [7:0] OFS_SS_Q = 8'h24;
  localparam logic [7:0] OFS_NOTCH_SEL = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;

  // reset (factory) values
  localparam logic [15:0] RST_FF_GAIN = 16'h0000;
  localparam logic [15:0] RST_FF_TC = 16'h0000;
  localparam logic [3:0] RST_SW_SEL = 4'h0;
  localparam logic [15:0] RST_FORCE_LVL = 16'h00C8;
  localparam logic [15:0] RST_SPEED_LVL = 16'h0000;
  localparam logic [15:0] RST_ACCEL_LVL = 16'h0000;
  localparam logic [15:0] RST_POSERR_LVL = 16'h0000;
  localparam logic [15:0] RST_LAG_TC = 16'h0064;
  localparam logic [15:0] RST_SS_FREQ = 16'h1388;
  localparam logic [15:0] RST_SS_Q = 16'h0032;

  // setting limits
  localparam logic [15:0] MAX_FF_GAIN = 16'h0064;
  localparam logic [15:0] MAX_FF_TC = 16'h1900;
  localparam logic [15:0] MAX_FORCE_LVL = 16'h0320;
  localparam logic [15:0] MAX_SPEED_LVL = 16'h2710;
  localparam logic [15:0] MAX_ACCEL_LVL = 16'h7530;
  localparam logic [15:0] MAX_POSERR_LVL = 16'h2710;
  localparam logic [15:0] MIN_SS_FREQ = 16'h0064;
  localparam logic [15:0] MAX_SS_FREQ = 16'h1388;
  localparam logic [15:0] SS_BYPASS_FREQ = 16'h1388;
  localparam logic [15:0] MIN_SS_Q = 16'h0032;
  localparam logic [15:0] MAX_SS_Q = 16'h0064;
  localparam logic [15:0] PERCENT_FULL = 16'h0064;

  // switching condition codes
  localparam logic [3:0] COND_FORCE = 4'h0;
  localparam logic [3:0] COND_SPEED = 4'h1;
  localparam logic [3:0] COND_ACCEL = 4'h2;
  localparam logic [3:0] COND_POSERR = 4'h3;
  localparam logic [3:0] COND_NONE = 4'h4;

  // loop timing: one update per LOOP_PERIOD_NS, time constants in TC_UNIT_NS steps
  localparam int LOOP_PERIOD_NS = 10000;
  localparam int TC_UNIT_NS = 10000;
  localparam int LAG_STEP = LOOP_PERIOD_NS / TC_UNIT_NS;
  // 2*pi*Ts per Hz in Q20, Ts = LOOP_PERIOD_NS; worked in 64 bits so the product cannot wrap
  localparam int W_SHIFT = 20;
  localparam int W_PER_HZ = int'((64'd628318 * 64'(LOOP_PERIOD_NS) * 64'd1048576 +
                                  64'd50000000000000) / 64'd100000000000000);

  function automatic logic [DATA_W-1:0] mag(input logic signed [DATA_W-1:0] v);
    mag = v[DATA_W-1] ? DATA_W'(-v) : DATA_W'(v);
  endfunction

endpackage

// ---- src/sltun_lag.sv ----
// first-order lag stage with runtime time constant
`timescale 1ns/1ps
`default_nettype none
module sltun_lag #(
  parameter int DW = 24,
  parameter int STEP = 1
) (
  input wire logic pclk,                 // clock
  input wire logic presetn,              // async reset, low
  input wire logic in_valid,             // one loop update
  input wire logic signed [DW-1:0] x,    // input sample
  input wire logic [15:0] tc,            // time constant, 0 = pass through
  output logic out_valid,                // output updated
  output logic signed [DW-1:0] y         // filtered sample
);
  localparam int FW = sltun_pkg::FRAC_W;
  localparam int SW = DW + FW + 2;
  localparam int MW = SW + 20;

  if (DW < 8 || STEP < 1) begin : g_bad_params
    $error("sltun_lag: bad parameters");
  end

  logic signed [SW-1:0] acc_r;
  logic signed [SW-1:0] acc_nxt;
  logic signed [SW-1:0] x_ext;
  logic signed [MW-1:0] step_prod;
  logic signed [MW-1:0] denom;

  assign x_ext = SW'(x) <<< FW;
  assign step_prod = MW'(x_ext - acc_r) * MW'(STEP);
  assign denom = MW'({1'b0, tc}) + MW'(STEP);
  // a zero constant means no smoothing at all
  assign acc_nxt = (tc == 16'h0000) ? x_ext : SW'(MW'(acc_r) + step_prod / denom);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= '0;
      y <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        acc_r <= acc_nxt;
        y <= DW'(acc_nxt >>> FW);
      end
    end
  end

  a_lag_passthru: assert property (@(posedge pclk) disable iff (!presetn)
    in_valid && tc == 16'h0000 |=> y == $past(x)) else $error("lag zero tc not passing");

endmodule // sltun_lag
`default_nettype wire

// ---- src/sltun_so2.sv ----
// second-order low pass (state variable) with bypass at top frequency
`timescale 1ns/1ps
`default_nettype none
module sltun_so2 #(
  parameter int DW = 24
) (
  input wire logic pclk,                 // clock
  input wire logic presetn,              // async reset, low
  input wire logic in_valid,             // one loop update
  input wire logic signed [DW-1:0] x,    // input sample
  input wire logic [15:0] freq,          // cutoff in Hz
  input wire logic [15:0] q,             // Q in 0.01 steps
  output logic out_valid,                // output updated
  output logic signed [DW-1:0] y         // filtered sample
);
  localparam int FW = sltun_pkg::FRAC_W;
  localparam int SW = DW + FW + 4;
  localparam int MW = SW + 24;

  if (DW < 8) begin : g_bad_width
    $error("sltun_so2: bad width");
  end

  logic signed [SW-1:0] lp_r;
  logic signed [SW-1:0] bp_r;
  logic signed [SW-1:0] x_ext;
  logic signed [MW-1:0] w;
  logic signed [MW-1:0] damp;
  logic signed [MW-1:0] hp;
  logic signed [SW-1:0] bp_nxt;
  logic signed [SW-1:0] lp_nxt;
  logic bypass;
  logic [15:0] q_safe;

  assign bypass = (freq == sltun_pkg::SS_BYPASS_FREQ);
  assign x_ext = SW'(x) <<< FW;
  assign w = MW'({1'b0, freq}) * MW'(sltun_pkg::W_PER_HZ);
  // q floor guards the divide; q below range is refused at the register
  assign q_safe = (q == 16'h0000) ? sltun_pkg::MIN_SS_Q : q;
  // signed operands throughout, or a negative band-pass state divides as unsigned
  assign damp = MW'(bp_r) * $signed(MW'({1'b0, sltun_pkg::PERCENT_FULL})) /
                $signed(MW'({1'b0, q_safe}));
  assign hp = MW'(x_ext) - MW'(lp_r) - damp;
  assign bp_nxt = SW'(MW'(bp_r) + ((w * hp) >>> sltun_pkg::W_SHIFT));
  assign lp_nxt = SW'(MW'(lp_r) + ((w * MW'(bp_nxt)) >>> sltun_pkg::W_SHIFT));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_r <= '0;
      bp_r <= '0;
      y <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
      if (in_valid && bypass) begin
        // preload state so leaving bypass starts without a step
        lp_r <= x_ext;
        bp_r <= '0;
        y <= x;
      end else if (in_valid) begin
        lp_r <= lp_nxt;
        bp_r <= bp_nxt;
        y <= DW'(lp_nxt >>> FW);
      end
    end
  end

  a_so2_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    in_valid && bypass |=> y == $past(x)) else $error("second step filter not bypassed");

endmodule // sltun_so2
`default_nettype wire

// ---- verification/sltun_tb.sv ----
// self-checking bench for the servo loop tuning block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic sample_valid = 1'b0;
  sltun_pkg::sltun_sample_type sample = '0;
  logic pos_ctrl_mode = 1'b1;
  logic [31:0] prdata, rd, po, ffo, fo;
  logic pready, pslverr, er, ff_valid, force_valid, p_only, notch1_en, notch2_en;
  logic signed [23:0] ff_out, force_out;
  logic [23:0] q [4];
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  sltun_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample(sample),
    .pos_ctrl_mode(pos_ctrl_mode), .ff_valid(ff_valid), .ff_out(ff_out),
    .force_valid(force_valid), .force_out(force_out), .p_only(p_only),
    .notch1_en(notch1_en), .notch2_en(notch2_en));
  initial forever #4 pclk = ~pclk;
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one loop update; results taken in the cycle each output stands
  task automatic smp(input logic [23:0] f, s, a, e, p, input logic pm);
    @(posedge pclk);
    sample_valid <= 1'b1;
    sample <= '{f, s, a, e, p};
    pos_ctrl_mode <= pm;
    @(posedge pclk);
    sample_valid <= 1'b0;
    @(posedge pclk);
    po = 32'(p_only);
    ffo = {8'h00, ff_out};
    chk("ff_valid", 32'(ff_valid), 32'h0000_0001);
    @(posedge pclk);
    fo = {8'h00, force_out};
    chk("force_valid", 32'(force_valid), 32'h0000_0001);
  endtask
  task automatic t_reset;
    logic [7:0] a [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
      8'h24, 8'h28};
    logic [15:0] v [11] = '{16'h0000, 16'h0000, 16'h0000, 16'h00C8, 16'h0000, 16'h0000,
      16'h0000, 16'h0064, 16'h1388, 16'h0032, 16'h0000};
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, a[i], 32'h0000_0000);
      chk("reset value", rd, {16'h0000, v[i]});
    end
  endtask
  task automatic t_refuse;
    apb(1'b1, 8'h00, 32'h0000_0065);
    chk("gain 101 err", 32'(er), 32'h0000_0001);
    apb(1'b1, 8'h20, 32'h0000_0063);
    chk("freq 99 err", 32'(er), 32'h0000_0001);
    apb(1'b1, 8'h2C, 32'h0000_0001);
    chk("status write err", 32'(er), 32'h0000_0001);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk("unmapped err", 32'(er), 32'h0000_0001);
    apb(1'b1, 8'h08, 32'h0000_0005);
    chk("select 5 err", 32'(er), 32'h0000_0001);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("gain kept", rd, 32'h0000_0000);
  endtask
  // each condition against its own level: above, negative above, equal
  task automatic t_mode;
    logic [23:0] x [3] = '{24'h00_000B, 24'hFF_FFF5, 24'h00_000A};
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 8'(8'h0C + 4 * c), 32'h0000_000A);
      apb(1'b1, 8'h08, 32'(c));
      for (int k = 0; k < 3; k++) begin
        q = '{default: 24'h00_0000};
        q[c] = x[k];
        smp(q[0], q[1], q[2], q[3], 24'h00_0000, 1'b1);
        chk("p_only", po, (k < 2) ? 32'h0000_0001 : 32'h0000_0000);
      end
    end
    smp(24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_000B, 24'h00_0000, 1'b0);
    chk("p_only pos off", po, 32'h0000_0000);
    apb(1'b1, 8'h08, 32'h0000_0004);
    smp(24'h00_07FF, 24'h00_07FF, 24'h00_07FF, 24'h00_07FF, 24'h00_0000, 1'b1);
    chk("p_only none", po, 32'h0000_0000);
  endtask
  // zero constants pass through, 5000 Hz bypasses the second stage
  task automatic t_path;
    apb(1'b1, 8'h00, 32'h0000_0032);
    chk("gain write err", 32'(er), 32'h0000_0000);
    apb(1'b1, 8'h04, 32'h0000_0000);
    apb(1'b1, 8'h1C, 32'h0000_0000);
    smp(24'h00_04D2, 24'h00_0000, 24'h00_0000, 24'h00_0000, 24'hFF_FF37, 1'b1);
    chk("ff_out", ffo, 32'h00FF_FF9C);
    chk("force_out", fo, 32'h0000_04D2);
    // a nonzero lag constant moves only part of the way to a new input
    apb(1'b1, 8'h1C, 32'h0000_0064);
    smp(24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000, 1'b1);
    chk("lag partial", 32'(fo > 0 && fo < 32'h0000_04D2), 32'h0000_0001);
    // below the top frequency the second stage smooths instead of passing through
    apb(1'b1, 8'h1C, 32'h0000_0000);
    apb(1'b1, 8'h20, 32'h0000_0064);
    chk("freq write err", 32'(er), 32'h0000_0000);
    smp(24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000, 1'b1);
    chk("second step", 32'(fo > 0 && fo < 32'h0000_04D2), 32'h0000_0001);
  endtask
  task automatic t_notch;
    apb(1'b1, 8'h28, 32'h0000_0101);
    repeat (2) @(posedge pclk);
    chk("notch1", 32'(notch1_en), 32'h0000_0001);
    chk("notch2", 32'(notch2_en), 32'h0000_0001);
    apb(1'b1, 8'h28, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("notch2 off", 32'(notch2_en), 32'h0000_0000);
  endtask
  // reset in mid-run clears the enables and restores factory settings
  task automatic t_rst2;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("notch1 in reset", 32'(notch1_en), 32'h0000_0000);
    presetn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("freq after reset", rd, 32'h0000_1388);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // run needs well under 2000 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      test_done;
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_refuse;
    t_mode;
    t_path;
    t_notch;
    t_rst2;
    test_done;
  end
endmodule // testbench
`default_nettype wire
